// >>> hw/rcl_return_config_unit.v
// Executes the return-from-interrupt and legacy configuration-load instructions.
`timescale 1ns/1ps
`include "rcl_map.vh"
module rcl_return_config_unit #(
	parameter PC_WIDTH = 13,
	parameter STACK_LOG2 = 3
) (
	input  wire                  clk,
	input  wire                  rst_b,
	input  wire                  clkEn,
	input  wire                  cycleStart,
	input  wire [13:0]           instruction,
	input  wire [7:0]            accumulator,
	input  wire                  callPush,
	input  wire [PC_WIDTH-1:0]   pushValue,
	input  wire                  interruptTaken,
	input  wire                  configWrite,
	input  wire [7:0]            configWriteData,
	input  wire                  icrWrite,
	input  wire [7:0]            icrWriteData,
	output reg  [PC_WIDTH-1:0]   pcLoadValue,
	output reg                   pcLoad,
	output reg                   flushFetch,
	output reg                   busy,
	output reg  [7:0]            configRegister,
	output reg  [7:0]            interruptControlRegister,
	output reg                   globalInterruptEnable,
	output reg  [STACK_LOG2-1:0] stackDepth
);
	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	localparam ST_IDLE   = 1'b0;
	localparam ST_SECOND = 1'b1;

	reg                  state;
	reg                  next_state;
	wire [PC_WIDTH-1:0]  returnStackTop;
	wire [STACK_LOG2-1:0] sp;
	wire                 isReturn;
	wire                 isConfigLoad;
	wire                 doPop;
	wire                 doPush;

	function matchOp;
		input [13:0] word;
		input [13:0] op;
		begin
			matchOp = (word == op);
		end
	endfunction

	assign isReturn = cycleStart && state == ST_IDLE
		&& matchOp(instruction, `RCL_OP_RETURN_FROM_INTERRUPT);
	assign isConfigLoad = cycleStart && state == ST_IDLE
		&& matchOp(instruction, `RCL_OP_CONFIG_LOAD);
	assign doPop = isReturn;
	assign doPush = callPush || interruptTaken;

	rcl_return_stack #(
		.PC_WIDTH   (PC_WIDTH),
		.DEPTH_LOG2 (STACK_LOG2)
	) u_stack (
		.clk            (clk),
		.rst_b          (rst_b),
		.clkEn          (clkEn),
		.push           (doPush),
		.pop            (doPop),
		.pushValue      (pushValue),
		.returnStackTop (returnStackTop),
		.stackPointer   (sp)
	);

	// ------------------------------------------------------------
	// Two-cycle sequencing
	// ------------------------------------------------------------
	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (isReturn) begin
					next_state = ST_SECOND;
				end
			end
			ST_SECOND: begin
				if (cycleStart) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= ST_IDLE;
			pcLoad <= 1'b0;
			pcLoadValue <= `RCL_PC_RESET;
			flushFetch <= 1'b0;
			busy <= 1'b0;
			stackDepth <= `RCL_SP_RESET;
		end else if (clkEn) begin
			state <= next_state;
			pcLoad <= isReturn;
			flushFetch <= isReturn;
			busy <= (next_state == ST_SECOND);
			stackDepth <= sp;
			if (isReturn) begin
				pcLoadValue <= returnStackTop;
			end
		end
	end

	// ------------------------------------------------------------
	// Configuration and interrupt control registers
	// ------------------------------------------------------------
	// A direct data-memory write and the legacy load share the register; the
	// legacy load wins if both land in the same cycle, as it is the later stage.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			configRegister <= `RCL_CONFIG_RESET;
		end else if (clkEn) begin
			if (isConfigLoad) begin
				configRegister <= accumulator;
			end else if (configWrite) begin
				configRegister <= configWriteData;
			end
		end
	end

	// Hardware set of the enable bit wins over a software write of the same cycle.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			interruptControlRegister <= `RCL_ICR_RESET;
			globalInterruptEnable <= 1'b0;
		end else if (clkEn) begin
			if (icrWrite) begin
				interruptControlRegister <= icrWriteData;
				globalInterruptEnable <= icrWriteData[`RCL_GIE_BIT];
			end
			if (interruptTaken) begin
				interruptControlRegister[`RCL_GIE_BIT] <= 1'b0;
				globalInterruptEnable <= 1'b0;
			end
			if (isReturn) begin
				interruptControlRegister[`RCL_GIE_BIT] <= 1'b1;
				globalInterruptEnable <= 1'b1;
			end
		end
	end
endmodule

// >>> hw/rcl_return_stack.v
// Hardware return stack with push and pop for the return and config-load unit.
`timescale 1ns/1ps
`include "rcl_map.vh"
module rcl_return_stack #(
	parameter PC_WIDTH = 13,
	parameter DEPTH_LOG2 = 3
) (
	input  wire                  clk,
	input  wire                  rst_b,
	input  wire                  clkEn,
	input  wire                  push,
	input  wire                  pop,
	input  wire [PC_WIDTH-1:0]   pushValue,
	output wire [PC_WIDTH-1:0]   returnStackTop,
	output wire [DEPTH_LOG2-1:0] stackPointer
);
	reg [PC_WIDTH-1:0]   entries [0:(1<<DEPTH_LOG2)-1];
	reg [DEPTH_LOG2-1:0] sp;

	// The stack is circular: overflow overwrites the oldest entry silently.
	assign returnStackTop = entries[sp - {{(DEPTH_LOG2-1){1'b0}}, 1'b1}];
	assign stackPointer = sp;

	always @(posedge clk) begin
		if (clkEn && push) begin
			entries[sp] <= pushValue;
		end
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sp <= `RCL_SP_RESET;
		end else if (clkEn) begin
			if (push && !pop) begin
				sp <= sp + {{(DEPTH_LOG2-1){1'b0}}, 1'b1};
			end else if (pop && !push) begin
				sp <= sp - {{(DEPTH_LOG2-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule

// >>> include/rcl_map.vh
// Opcodes, field positions, reset values and timing counts for the return and config-load unit.
`ifndef RCL_MAP_VH
`define RCL_MAP_VH
`define RCL_OP_RETURN_FROM_INTERRUPT 14'h0009
`define RCL_OP_CONFIG_LOAD           14'h0062
`define RCL_GIE_BIT                  7
`define RCL_CONFIG_RESET             8'hFF
`define RCL_ICR_RESET                8'h00
`define RCL_PC_RESET                 13'h0000
`define RCL_SP_RESET                 3'h0
`define RCL_RETURN_CYCLES            2
`define RCL_Q_PHASES                 4
`endif

// >>> verif/rcl_unit_monitor.sv
// Concurrent checks on the return and config-load unit ports.
`timescale 1ns/1ps
module rcl_unit_monitor (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        clkEn,
	input wire logic        cycleStart,
	input wire logic [13:0] instruction,
	input wire logic [7:0]  accumulator,
	input wire logic        configWrite,
	input wire logic [7:0]  configWriteData,
	input wire logic        pcLoad,
	input wire logic        flushFetch,
	input wire logic        busy,
	input wire logic [7:0]  configRegister,
	input wire logic        globalInterruptEnable
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	wire logic retTake = clkEn & cycleStart & !busy & (instruction == 14'h0009);
	wire logic cfgTake = clkEn & cycleStart & !busy & (instruction == 14'h0062);
	sequence sRetAnswer;
		pcLoad && flushFetch && busy;
	endsequence
	sequence sRetDone;
		!pcLoad && !flushFetch;
	endsequence
	AST_RET_POP: assert property (retTake |=> sRetAnswer ##0 globalInterruptEnable)
		else $error("return gave no load");
	AST_RET_TWO: assert property (retTake |=> sRetAnswer ##1 sRetDone)
		else $error("return length wrong");
	AST_PC_CAUSE: assert property (pcLoad |-> $past(retTake))
		else $error("load without return");
	AST_CFG_LOAD: assert property (cfgTake |=> configRegister == $past(accumulator))
		else $error("config load wrong");
	AST_CFG_DIRECT: assert property (clkEn && configWrite && !cfgTake |=>
		configRegister == $past(configWriteData))
		else $error("config write wrong");
endmodule
bind rcl_return_config_unit rcl_unit_monitor mon_u (.clk(clk), .rst_b(rst_b), .clkEn(clkEn),
	.cycleStart(cycleStart), .instruction(instruction), .accumulator(accumulator),
	.configWrite(configWrite), .configWriteData(configWriteData), .pcLoad(pcLoad),
	.flushFetch(flushFetch), .busy(busy), .configRegister(configRegister),
	.globalInterruptEnable(globalInterruptEnable));

// >>> verif/test_rcl_return_config_unit.sv
// Self-checking testbench for the return and config-load unit.
`timescale 1ns/1ps
module test_rcl_return_config_unit;
	logic        clk, rst_b, cycleStart, interruptTaken, configWrite, pcLoad, global_interrupt_enable;
	logic        flushFetch, busy;
	logic [2:0]  stackDepth;
	logic [7:0]  icr;
	logic [13:0] instruction;
	logic [7:0]  accumulator, configWriteData, configRegister, expCfg;
	logic [12:0] pushValue, pcLoadValue;
	logic [12:0] stk[$], expPc[$];
	int          n_mismatch, cmp_count, seed;
	always #25 clk = ~clk;
	rcl_return_config_unit dut_u (.clk(clk), .rst_b(rst_b), .clkEn(1'b1),
		.cycleStart(cycleStart), .instruction(instruction), .accumulator(accumulator),
		.callPush(1'b0), .pushValue(pushValue), .interruptTaken(interruptTaken),
		.configWrite(configWrite), .configWriteData(configWriteData), .icrWrite(1'b0),
		.icrWriteData(8'h00), .pcLoadValue(pcLoadValue), .pcLoad(pcLoad),
		.flushFetch(flushFetch), .busy(busy), .configRegister(configRegister),
		.interruptControlRegister(icr), .globalInterruptEnable(global_interrupt_enable), .stackDepth(stackDepth));
	task chk(input string name, input logic [12:0] exp, input logic [12:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task test_done;
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task instr(input logic [13:0] op);
		@(negedge clk);
		cycleStart = 1;
		instruction = op;
		accumulator = $random(seed);
		@(negedge clk);
		cycleStart = 0;
	endtask
	always @(negedge clk)
		if (pcLoad === 1'b1) begin
			chk("pc", expPc.size() ? expPc.pop_front() : 13'h1FFF, pcLoadValue);
			chk("flush", 13'h0001, {12'h000, flushFetch});
		end
	initial begin
		clk = 0;
		rst_b = 0;
		{cycleStart, interruptTaken, configWrite} = 3'h0;
		instruction = 14'h0000;
		accumulator = 8'h00;
		pushValue = 13'h0000;
		configWriteData = 8'h00;
		seed = 96548;
		expCfg = 8'hFF;
		repeat (6) @(negedge clk);
		rst_b = 1;
		chk("cfg", {5'h00, expCfg}, {5'h00, configRegister});
		repeat (3) begin
			@(negedge clk);
			interruptTaken = 1;
			pushValue = $random(seed);
			stk.push_back(pushValue);
		end
		@(negedge clk);
		interruptTaken = 0;
		chk("gie", 13'h0000, {12'h000, global_interrupt_enable});
		@(negedge clk);
		chk("depth", 13'h0003, {10'h000, stackDepth});
		repeat (3) begin
			expPc.push_back(stk.pop_back());
			instr(14'h0009);
			chk("busy", 13'h0001, {12'h000, busy});
			instr(14'h0062);
			chk("busy", 13'h0000, {12'h000, busy});
		end
		chk("gie", 13'h0001, {12'h000, global_interrupt_enable});
		chk("icr", 13'h0001, {12'h000, icr[7]});
		chk("depth", 13'h0000, {10'h000, stackDepth});
		chk("cfg", {5'h00, expCfg}, {5'h00, configRegister});
		instr(14'h0062);
		expCfg = accumulator;
		chk("cfg", {5'h00, expCfg}, {5'h00, configRegister});
		configWrite = 1;
		configWriteData = $random(seed);
		@(negedge clk);
		configWrite = 0;
		chk("cfg", {5'h00, configWriteData}, {5'h00, configRegister});
		test_done;
	end
	initial begin
		#100000;
		n_mismatch++;
		test_done;
	end
endmodule
